// *** rtl/tfm_mode_ctrl.sv ***
// Feature-mode control register bank of a multi-channel PWM/capture timer.
// Assumes an Avalon-MM master on i_ref_clk; triggers and faults are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module tfm_mode_ctrl #(
    parameter int unsigned CHANNELS = tfm_pkg::CHAN_N
) (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_srst,
    input  wire logic [tfm_pkg::ADDR_W-1:0]   i_avs_address,
    input  wire logic                         i_avs_read,
    input  wire logic                         i_avs_write,
    input  wire logic [tfm_pkg::DATA_W-1:0]   i_avs_writedata,
    input  wire logic [3:0]                   i_avs_byteenable,
    output logic      [tfm_pkg::DATA_W-1:0]   o_avs_readdata,
    output logic                              o_avs_waitrequest,
    input  wire logic [tfm_pkg::CHAN_N-1:0]   i_fault_detect,
    input  wire logic                         i_sw_trigger,
    input  wire logic                         i_hw_trigger,
    output tfm_pkg::tfm_fault_cfg_type        o_fault_cfg,
    output logic                              o_capture_test,
    output logic                              o_extended_enable,
    output tfm_pkg::tfm_sync_upd_type         o_sync_upd,
    output logic                              o_chan_init,
    output logic      [tfm_pkg::CHAN_N-1:0]   o_chan_init_value,
    output logic                              o_irq
);
    import tfm_pkg::*;

    // Even-channel mask and port widths are fixed at the package count
    if (CHANNELS != CHAN_N) begin : g_chan_check
        $error("tfm_mode_ctrl: CHANNELS must equal CHAN_N");
    end

    // Bus handshake state
    logic              wait_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              req;
    logic              wr_go;
    logic              rd_go;
    logic              lane0;

    // Control state
    tfm_fault_mode_type fmode_ff;
    logic               firq_en_ff;
    logic               capture_test_enable_ff;
    logic               restrict_ff;
    logic               write_protect_disable_ff;
    logic               ext_en_ff;
    logic               write_protect_enable_seen_ff;
    logic               sync_sel_ff;
    logic [CHAN_N-1:0]  output_initial_values_ff;
    logic [IRQ_N-1:0]   irq_en_ff;

    // Output flops
    tfm_fault_cfg_type  fault_cfg_ff;
    tfm_sync_upd_type   sync_upd_ff;
    logic               chan_init_ff;
    logic [CHAN_N-1:0]  chan_val_ff;

    // Interrupt wiring
    logic [IRQ_N-1:0]   irq_event;
    logic [IRQ_N-1:0]   irq_clear;
    logic [IRQ_N-1:0]   irq_gate;
    logic [IRQ_N-1:0]   irq_status;
    logic               irq_w;
    logic [CHAN_N-1:0]  nxt_chan_en;

    // Decoded write strobes; lane 0 carries every field
    logic               wr_mode;
    logic               wr_prot;
    logic               wr_sync;
    logic               wr_oinit;
    logic               wr_iclr;
    logic               wr_ien;
    logic               init_go;

    function automatic logic hit(input logic [ADDR_W-1:0] off);
        return i_avs_address == off;
    endfunction

    // Request completes on the edge where waitrequest reads low
    assign req   = i_avs_read | i_avs_write;
    assign wr_go = i_avs_write & ~wait_ff;
    assign rd_go = i_avs_read & ~wait_ff;
    assign lane0 = i_avs_byteenable[0];

    // Write strobes shared by the field processes
    assign wr_mode  = wr_go & lane0 & hit(OFF_MODE);
    assign wr_prot  = wr_go & lane0 & hit(OFF_PROTECT);
    assign wr_sync  = wr_go & lane0 & hit(OFF_SYNCCFG);
    assign wr_oinit = wr_go & lane0 & hit(OFF_OUTPUT_INITIAL_VALUES);
    assign wr_iclr  = wr_go & lane0 & hit(OFF_IRQ_CLR);
    assign wr_ien   = wr_go & lane0 & hit(OFF_IRQ_EN);
    // Strobe bit is acted on, never stored
    assign init_go  = wr_mode & i_avs_writedata[BIT_INIT];

    // One wait cycle per access; flop-driven waitrequest
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~(req & wait_ff);
        end
    end

    // Read mux sampled in the wait cycle, stands at the completing edge
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_ff <= '0;
        end else if (i_avs_read & wait_ff) begin
            rdata_ff <= '0;
            if (hit(OFF_MODE)) begin
                rdata_ff[BIT_FIRQ_EN]            <= firq_en_ff;
                rdata_ff[LSB_FMODE +: 2]         <= fmode_ff;
                rdata_ff[BIT_CAPTURE_TEST_ENABLE]            <= capture_test_enable_ff;
                rdata_ff[BIT_RESTRICT]           <= restrict_ff;
                rdata_ff[BIT_WRITE_PROTECT_DISABLE]              <= write_protect_disable_ff;
                rdata_ff[BIT_INIT]               <= 1'b0;
                rdata_ff[BIT_EXT_EN]             <= ext_en_ff;
            end else if (hit(OFF_PROTECT)) begin
                rdata_ff[BIT_WRITE_PROTECT_ENABLE]               <= ~write_protect_disable_ff;
            end else if (hit(OFF_SYNCCFG)) begin
                rdata_ff[BIT_SYNC_SEL]           <= sync_sel_ff;
            end else if (hit(OFF_OUTPUT_INITIAL_VALUES)) begin
                rdata_ff[CHAN_N-1:0]             <= output_initial_values_ff;
            end else if (hit(OFF_IRQ_ST)) begin
                rdata_ff[IRQ_N-1:0]              <= irq_status;
            end else if (hit(OFF_IRQ_EN)) begin
                rdata_ff[IRQ_N-1:0]              <= irq_en_ff;
            end
        end
    end

    // Protected fields: only while write protection is off
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            fmode_ff   <= tfm_fault_mode_type'(RST_FMODE);
            capture_test_enable_ff <= RST_FLAG;
            ext_en_ff  <= RST_FLAG;
        end else if (wr_mode & write_protect_disable_ff) begin
            fmode_ff   <= tfm_fault_mode_type'(i_avs_writedata[LSB_FMODE +: 2]);
            capture_test_enable_ff <= i_avs_writedata[BIT_CAPTURE_TEST_ENABLE];
            ext_en_ff  <= i_avs_writedata[BIT_EXT_EN];
        end
    end

    // Unprotected mode bits take effect regardless of protection
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            firq_en_ff  <= RST_FLAG;
            restrict_ff <= RST_FLAG;
        end else if (wr_mode) begin
            firq_en_ff  <= i_avs_writedata[BIT_FIRQ_EN];
            restrict_ff <= i_avs_writedata[BIT_RESTRICT];
        end
    end

    // Read of the enable bit as 1 arms the unlock; a later write to the mode or protect register disarms it
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            write_protect_enable_seen_ff <= RST_FLAG;
        end else if (rd_go & hit(OFF_PROTECT) & ~write_protect_disable_ff) begin
            write_protect_enable_seen_ff <= 1'b1;
        end else if (wr_go & (hit(OFF_MODE) | hit(OFF_PROTECT))) begin
            write_protect_enable_seen_ff <= 1'b0;
        end
    end

    // Disable bit: reset loads 1, cleared by enable write, set after reset only by the armed sequence
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            write_protect_disable_ff <= RST_WRITE_PROTECT_DISABLE;
        end else if (wr_prot & i_avs_writedata[BIT_WRITE_PROTECT_ENABLE]) begin
            write_protect_disable_ff <= 1'b0;
        end else if (wr_mode & i_avs_writedata[BIT_WRITE_PROTECT_DISABLE]
                     & write_protect_enable_seen_ff) begin
            write_protect_disable_ff <= 1'b1;
        end
    end

    // Scheme select: the alternate scheme bypasses the restriction bit
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sync_sel_ff <= RST_FLAG;
        end else if (wr_sync) begin
            sync_sel_ff <= i_avs_writedata[BIT_SYNC_SEL];
        end
    end

    // Initial values reach the channels only through the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            output_initial_values_ff <= RST_OUTPUT_INITIAL_VALUES;
        end else if (wr_oinit) begin
            output_initial_values_ff <= i_avs_writedata[CHAN_N-1:0];
        end
    end

    // Interrupt enables; status keeps latching while disabled
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            irq_en_ff <= RST_IRQ;
        end else if (wr_ien) begin
            irq_en_ff <= i_avs_writedata[IRQ_N-1:0];
        end
    end

    // Init strobe holds no state; one-cycle load pulse
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            chan_init_ff <= 1'b0;
            chan_val_ff  <= RST_OUTPUT_INITIAL_VALUES;
        end else begin
            chan_init_ff <= init_go;
            if (init_go) begin
                chan_val_ff <= output_initial_values_ff;
            end
        end
    end

    // Fault channel enables from the mode field
    always_comb begin
        nxt_chan_en = '0;
        case (fmode_ff)
            TFM_FAULT_OFF:      nxt_chan_en = '0;
            TFM_FAULT_EVEN_MAN: nxt_chan_en = 8'h55;
            TFM_FAULT_ALL_MAN:  nxt_chan_en = 8'hff;
            TFM_FAULT_ALL_AUTO: nxt_chan_en = 8'hff;
            default:            nxt_chan_en = '0;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            fault_cfg_ff <= '0;
        end else begin
            fault_cfg_ff.chan_enable <= nxt_chan_en;
            fault_cfg_ff.auto_clear  <= (fmode_ff == TFM_FAULT_ALL_AUTO);
        end
    end

    // Trigger routing; restriction ignored under the alternate scheme
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sync_upd_ff <= '0;
        end else if (restrict_ff & ~sync_sel_ff) begin
            sync_upd_ff.modulo  <= i_sw_trigger;
            sync_upd_ff.compare <= i_sw_trigger;
            sync_upd_ff.mask    <= i_hw_trigger;
            sync_upd_ff.counter <= i_hw_trigger;
        end else begin
            sync_upd_ff.modulo  <= i_sw_trigger | i_hw_trigger;
            sync_upd_ff.compare <= i_sw_trigger | i_hw_trigger;
            sync_upd_ff.mask    <= i_sw_trigger | i_hw_trigger;
            sync_upd_ff.counter <= i_sw_trigger | i_hw_trigger;
        end
    end

    // Fault only counts on a channel whose fault control is on
    assign irq_event[IRQ_FAULT] = |(i_fault_detect & nxt_chan_en);
    assign irq_event[IRQ_INIT]  = chan_init_ff;
    assign irq_clear = wr_iclr ? i_avs_writedata[IRQ_N-1:0] : '0;
    // Fault line also needs the mode register's own interrupt enable
    assign irq_gate  = irq_en_ff & {1'b1, firq_en_ff};

    tfm_irq_unit #(
        .N (IRQ_N)
    ) u_irq (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_event   (irq_event),
        .i_clear   (irq_clear),
        .i_enable  (irq_gate),
        .o_status  (irq_status),
        .o_irq     (irq_w)
    );

    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_fault_cfg       = fault_cfg_ff;
    assign o_capture_test    = capture_test_enable_ff;
    assign o_extended_enable = ext_en_ff;
    assign o_sync_upd        = sync_upd_ff;
    assign o_chan_init       = chan_init_ff;
    assign o_chan_init_value = chan_val_ff;
    assign o_irq             = irq_w;
endmodule
`default_nettype wire

// *** pkg/tfm_pkg.sv ***
// Package: register map, field positions, reset values and carrier types of the
// timer feature-mode control block.
// Assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses.
package tfm_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CHAN_N = 8;
    localparam int unsigned IRQ_N  = 2;

    // Byte offsets
    localparam logic [ADDR_W-1:0] OFF_MODE    = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_PROTECT = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_SYNCCFG = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_OUTPUT_INITIAL_VALUES = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 5'h18;

    // Mode register fields
    localparam int unsigned BIT_EXT_EN   = 0;
    localparam int unsigned BIT_INIT     = 1;
    localparam int unsigned BIT_WRITE_PROTECT_DISABLE    = 2;
    localparam int unsigned BIT_RESTRICT = 3;
    localparam int unsigned BIT_CAPTURE_TEST_ENABLE  = 4;
    localparam int unsigned LSB_FMODE    = 5;
    localparam int unsigned BIT_FIRQ_EN  = 7;
    // Protect register field
    localparam int unsigned BIT_WRITE_PROTECT_ENABLE     = 6;
    // Sync config field
    localparam int unsigned BIT_SYNC_SEL = 0;
    // Interrupt status bits
    localparam int unsigned IRQ_FAULT    = 0;
    localparam int unsigned IRQ_INIT     = 1;

    // Reset values
    localparam logic [1:0]        RST_FMODE   = 2'h0;
    localparam logic              RST_WRITE_PROTECT_DISABLE   = 1'b1;
    localparam logic              RST_FLAG    = 1'b0;
    localparam logic [CHAN_N-1:0] RST_OUTPUT_INITIAL_VALUES = 8'h00;
    localparam logic [IRQ_N-1:0]  RST_IRQ     = 2'h0;

    typedef enum logic [1:0] {
        TFM_FAULT_OFF      = 2'b00,
        TFM_FAULT_EVEN_MAN = 2'b01,
        TFM_FAULT_ALL_MAN  = 2'b10,
        TFM_FAULT_ALL_AUTO = 2'b11
    } tfm_fault_mode_type;

    typedef struct packed {
        logic [CHAN_N-1:0] chan_enable;
        logic              auto_clear;
    } tfm_fault_cfg_type;

    typedef struct packed {
        logic modulo;
        logic compare;
        logic mask;
        logic counter;
    } tfm_sync_upd_type;

endpackage

// *** rtl/tfm_irq_unit.sv ***
// Interrupt unit: sticky status, write-one-to-clear, enable, one level output.
// Assumes event and clear pulses are synchronous to i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module tfm_irq_unit #(
    parameter int unsigned N = 2
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_srst,
    input  wire logic [N-1:0] i_event,
    input  wire logic [N-1:0] i_clear,
    input  wire logic [N-1:0] i_enable,
    output logic      [N-1:0] o_status,
    output logic              o_irq
);
    import tfm_pkg::*;

    // Status must fit one bus word
    if (N < 1 || N > DATA_W) begin : g_n_check
        $error("tfm_irq_unit: N out of range");
    end

    logic [N-1:0] status_ff;
    logic         irq_ff;

    // Set beats clear so no event is lost
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~i_clear) | i_event;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(((status_ff & ~i_clear) | i_event) & i_enable);
        end
    end

    assign o_status = status_ff;
    assign o_irq    = irq_ff;
endmodule
`default_nettype wire

// *** test/tfm_mode_ctrl_monitor.sv ***
// Checker for the feature-mode control bank: bus answer, sync routing, init strobe.
// Sees only the top module's ports; bound to it at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module tfm_mode_ctrl_monitor
    import tfm_pkg::*;
(
    input wire logic                    i_ref_clk,
    input wire logic                    i_srst,
    input wire logic [ADDR_W-1:0]       i_avs_address,
    input wire logic                    i_avs_read,
    input wire logic                    i_avs_write,
    input wire logic [DATA_W-1:0]       i_avs_writedata,
    input wire logic [3:0]              i_avs_byteenable,
    input wire logic [DATA_W-1:0]       o_avs_readdata,
    input wire logic                    o_avs_waitrequest,
    input wire logic                    i_sw_trigger,
    input wire logic                    i_hw_trigger,
    input wire tfm_fault_cfg_type       o_fault_cfg,
    input wire logic                    o_capture_test,
    input wire logic                    o_extended_enable,
    input wire tfm_sync_upd_type        o_sync_upd,
    input wire logic                    o_chan_init
);
    logic wr_done;
    logic trig;
    logic shadow_restrict_ff;
    logic shadow_sel_ff;
    logic routed;
    assign wr_done = i_avs_write & ~o_avs_waitrequest;
    assign trig = i_sw_trigger | i_hw_trigger;
    assign routed = shadow_restrict_ff & ~shadow_sel_ff;

    // Routing bits rebuilt from completed writes, not read from the design
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            shadow_restrict_ff <= RST_FLAG;
            shadow_sel_ff      <= RST_FLAG;
        end else if (wr_done && i_avs_byteenable[0]) begin
            if (i_avs_address == OFF_MODE) begin
                shadow_restrict_ff <= i_avs_writedata[BIT_RESTRICT];
            end
            if (i_avs_address == OFF_SYNCCFG) begin
                shadow_sel_ff <= i_avs_writedata[BIT_SYNC_SEL];
            end
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    AST_WAIT_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer timing wrong");
    AST_RSVD_ZERO: assert property (i_avs_read && !o_avs_waitrequest
        |-> o_avs_readdata[31:8] == 24'h0) else $error("upper read bits not zero");
    AST_INIT_READ_ZERO: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address == OFF_MODE |-> !o_avs_readdata[BIT_INIT]) else $error("init bit read 1");
    AST_EVEN_MASK: assert property (o_fault_cfg.chan_enable != 8'h0
        |-> o_fault_cfg.chan_enable inside {8'h55, 8'hff}) else $error("bad channel set");
    AST_AUTO_ALL: assert property (o_fault_cfg.auto_clear
        |-> o_fault_cfg.chan_enable == 8'hff) else $error("auto clear not on all");
    AST_SYNC_CAUSE: assert property (o_sync_upd != 4'h0 |-> $past(trig))
        else $error("update without trigger");
    AST_SW_MODCMP: assert property (i_sw_trigger |=> o_sync_upd.modulo && o_sync_upd.compare)
        else $error("software trigger lost");
    AST_HW_MASKCNT: assert property (i_hw_trigger |=> o_sync_upd.mask && o_sync_upd.counter)
        else $error("hardware trigger lost");
    AST_INIT_PULSE: assert property (wr_done && i_avs_address == OFF_MODE && i_avs_byteenable[0]
        |=> o_chan_init == $past(i_avs_writedata[BIT_INIT])) else $error("init pulse wrong");
    AST_INIT_CAUSE: assert property (o_chan_init |-> $past(wr_done))
        else $error("init pulse without write");
    AST_PROT_CHANGE: assert property ($changed({o_capture_test, o_extended_enable, o_fault_cfg})
        |-> $past(wr_done) || $past(wr_done, 2)) else $error("mode output moved alone");
    AST_SW_RESTRICTED: assert property (i_sw_trigger && !i_hw_trigger && routed
        |=> !o_sync_upd.mask && !o_sync_upd.counter)
        else $error("software trigger reached mask");
    AST_HW_RESTRICTED: assert property (i_hw_trigger && !i_sw_trigger && routed
        |=> !o_sync_upd.modulo && !o_sync_upd.compare)
        else $error("hardware trigger reached modulo");
    AST_OPEN_ROUTE: assert property (trig && !routed
        |=> o_sync_upd == 4'hf) else $error("open routing incomplete");
endmodule
bind tfm_mode_ctrl tfm_mode_ctrl_monitor mon_u (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_sw_trigger(i_sw_trigger),
    .i_hw_trigger(i_hw_trigger), .o_fault_cfg(o_fault_cfg), .o_capture_test(o_capture_test),
    .o_extended_enable(o_extended_enable), .o_sync_upd(o_sync_upd), .o_chan_init(o_chan_init)
);
`default_nettype wire

// *** test/timer_feature_mode_control_tb.sv ***
// Self-checking bench of the feature-mode control bank.
// Assumes the package offsets and a one-wait-cycle Avalon slave.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module timer_feature_mode_control_tb;
    import tfm_pkg::*;
    logic              clk = 0, srst = 1, rd_r = 0, wr_r = 0, sw = 0, hw = 0;
    logic [4:0]        addr = 5'h0;
    logic [31:0]       wdata = 32'h0, rdata, ev;
    logic [7:0]        fault = 8'h0, civ;
    logic              wait_o, capt, ext, cinit, irq;
    tfm_fault_cfg_type fcfg;
    tfm_sync_upd_type  upd;
    logic [31:0]       expq[$];
    int                err_count = 0, cmp_count = 0;

    tfm_mode_ctrl dut_u (.i_ref_clk(clk), .i_srst(srst), .i_avs_address(addr),
        .i_avs_read(rd_r), .i_avs_write(wr_r), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_o),
        .i_fault_detect(fault), .i_sw_trigger(sw), .i_hw_trigger(hw), .o_fault_cfg(fcfg),
        .o_capture_test(capt), .o_extended_enable(ext), .o_sync_upd(upd),
        .o_chan_init(cinit), .o_chan_init_value(civ), .o_irq(irq));

    always #5 clk = ~clk;

    task automatic conclude();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic [4:0] a, input logic [31:0] d, input logic is_rd);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd_r <= is_rd;
        wr_r <= !is_rd;
        do @(posedge clk); while (wait_o !== 1'b0);
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(a, d, 1'b0);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(a, 32'h0, 1'b1);
    endtask
    task automatic trig(input logic s, input logic h, input logic [3:0] e);
        @(posedge clk);
        sw <= s;
        hw <= h;
        @(posedge clk);
        sw <= 1'b0;
        hw <= 1'b0;
        #1 `CHK(upd, e)
    endtask
    task automatic flt(input logic [7:0] f);
        @(posedge clk);
        fault <= f;
        @(posedge clk);
        fault <= 8'h0;
        repeat (2) @(posedge clk);
    endtask

    // Oldest read expectation meets the completing read
    always @(posedge clk) begin
        if (rd_r && wait_o === 1'b0) begin
            ev = expq.pop_front();
            `CHK(rdata, ev)
        end
    end

    initial begin
        #100us;
        err_count++;
        conclude();
    end

    initial begin
        logic [7:0] ce;
        logic [7:0] v;
        void'($urandom(32'hbf5a));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(OFF_MODE, 32'h4);
        rd(OFF_PROTECT, 32'h0);
        rd(5'h1c, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(OFF_MODE, 32'h17 | (m << 5));
            @(posedge clk);
            ce = (m == 0) ? 8'h00 : (m == 1) ? 8'h55 : 8'hff;
            #1 `CHK(fcfg, {ce, 1'(m == 3)})
            `CHK({capt, ext}, 2'b11)
            rd(OFF_MODE, 32'h15 | (m << 5));
        end
        wr(OFF_PROTECT, 32'h40);
        rd(OFF_MODE, 32'h71);
        rd(OFF_PROTECT, 32'h40);
        // Write with bit 2 clear disarms the pending unlock
        wr(OFF_MODE, 32'h08);
        rd(OFF_MODE, 32'h79);
        wr(OFF_MODE, 32'h0c);
        rd(OFF_MODE, 32'h79);
        rd(OFF_PROTECT, 32'h40);
        wr(OFF_MODE, 32'h0c);
        rd(OFF_MODE, 32'h7d);
        wr(OFF_MODE, 32'h08);
        rd(OFF_MODE, 32'h0c);
        `CHK({capt, ext}, 2'b00)
        for (int k = 0; k < 4; k++) begin
            wr(OFF_SYNCCFG, 32'(k >> 1));
            wr(OFF_MODE, 32'h04 | ((k & 1) << 3));
            trig(1'b1, 1'b0, (k == 1) ? 4'b1100 : 4'b1111);
            trig(1'b0, 1'b1, (k == 1) ? 4'b0011 : 4'b1111);
        end
        trig(1'b1, 1'b1, 4'b1111);
        wr(OFF_IRQ_EN, 32'h3);
        for (int j = 0; j < 2; j++) begin
            v = 8'($urandom);
            wr(OFF_OUTPUT_INITIAL_VALUES, {24'h0, v});
            wr(OFF_MODE, 32'h04 | (j << 1));
            #1 `CHK(cinit, 1'(j))
            if (j == 1) `CHK(civ, v)
        end
        rd(OFF_IRQ_ST, 32'h2);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_CLR, 32'h2);
        rd(OFF_IRQ_ST, 32'h0);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_EN, 32'h1);
        wr(OFF_MODE, 32'h06);
        rd(OFF_IRQ_ST, 32'h2);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_CLR, 32'h3);
        wr(OFF_MODE, 32'ha4);
        flt(8'haa);
        rd(OFF_IRQ_ST, 32'h0);
        flt(8'h1 << (2 * ($urandom % 4)));
        rd(OFF_IRQ_ST, 32'h1);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_CLR, 32'h1);
        wr(OFF_MODE, 32'h24);
        flt(8'h04);
        rd(OFF_IRQ_ST, 32'h1);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_CLR, 32'h1);
        wr(OFF_MODE, 32'hc4);
        flt(8'h80);
        rd(OFF_IRQ_ST, 32'h1);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_CLR, 32'h1);
        wr(OFF_MODE, 32'h04);
        flt(8'hff);
        rd(OFF_IRQ_ST, 32'h0);
        `CHK(irq, 1'b0)
        conclude();
    end
endmodule
`default_nettype wire
